// ==== rtl/pipe_tx_lane.sv ====
`timescale 1ns/1ps
`include "pipe_tx_lane_params.svh"

// Notes on behaviour
// - Each lane presents its 32-bit transmit word on its own output bus.
// - Four control flags, one per byte; 0 marks data, 1 marks control.
// - Flag bit 0 belongs to the lowest byte, higher bits to higher bytes.
// - Control flags matter only at Gen1 and Gen2; written as zero at Gen3.
// - At Gen3 a skip qualifier marks the word valid (1) or ignored (0).
// - De-emphasis follows the value learnt from training; user need not touch it. Here software loads it into control bit 2.
// - Detect request asks the PHY for receiver detection or loopback.
// - Idle request forces the lane transmitter into electrical idle.
// - Three-bit voltage margin comes from link control 2; simulation only.
// - Swing select high asks full swing, low asks half swing.
// - Gen3 block header: 01 ordered set block, 10 data block.
// - Rate 00 is Gen1, 01 Gen2, 1x Gen3.
// - At Gen3 a block start output flags each block's first word.
module pipe_tx_lane
    import pipe_tx_lane_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic [31:0] lane_tx_word_out,
    output logic [3:0] lane_tx_ctrl_byte_flags_out,
    output logic lane_tx_skip_qualifier_out,
    output logic lane_tx_block_start_out,
    output logic [1:0] lane_tx_block_header_out,
    output logic lane_tx_deemphasis_sel_out,
    output logic lane_rx_detect_request_out,
    output logic lane_tx_idle_request_out,
    output logic [2:0] lane_tx_voltage_margin_out,
    output logic lane_tx_full_swing_out
);

    // ****************************************
    // Decode helpers
    // ****************************************
    // Rate code to signal set; bit 1 alone picks Gen3, so bit 0 is
    // then ignored and both Gen3 codes behave the same
    function automatic rate_sel_t decode_rate(input logic [1:0] code);
        if (code[1]) begin
            decode_rate = RATE_SEL_GEN3;
        end else if (code == `RATE_GEN2) begin
            decode_rate = RATE_SEL_GEN2;
        end else begin
            decode_rate = RATE_SEL_GEN1;
        end
    endfunction : decode_rate

    // Header legal only with the two defined encodings;
    // 00 and 11 are caught here and never reach the pins
    function automatic logic header_ok(input logic [1:0] hdr);
        header_ok = (hdr == `HDR_ORDERED_SET) || (hdr == `HDR_DATA_BLOCK);
    endfunction : header_ok

    // One strobe aimed at one register word;
    // shared by every write decode below
    function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
            input logic [3:0] target);
        reg_hit = strobe && (addr == target);
    endfunction : reg_hit

    // ****************************************
    // State and decoded strobes
    // ****************************************
    // Configuration, status and counter words
    logic [31:0] ctrl_ff;
    logic [31:0] sent_ff;
    logic bad_hdr_ff;
    rate_sel_t rate_ff;

    // Per-register write strobes
    logic wr_ctrl;
    logic wr_tx_word;
    logic wr_txc;
    logic wr_status;

    // Fields of the transmit control word on the bus
    logic [3:0] txc_flags;
    logic [1:0] txc_hdr;
    logic txc_blkst;
    logic txc_valid;

    // Derived conditions and readback images
    logic gen3;
    logic hdr_legal;
    logic bad_hdr_evt;
    logic bad_hdr_clr;
    logic [31:0] txc_readback;
    logic [31:0] status_readback;

    // Write strobes, one per writable register word (none for the sent count);
    // reads are decoded in the read mux instead
    assign wr_ctrl = reg_hit(wr_in, addr_in, `ADDR_CTRL);
    assign wr_tx_word = reg_hit(wr_in, addr_in, `ADDR_TX_WORD);
    assign wr_txc = reg_hit(wr_in, addr_in, `ADDR_TX_CTRL);
    assign wr_status = reg_hit(wr_in, addr_in, `ADDR_STATUS);

    // Transmit control word fields, taken straight off the bus;
    // they only matter in the cycle of a write to that word
    assign txc_flags = wdata_in[`TXC_FLAGS_HI:`TXC_FLAGS_LO];
    assign txc_hdr = wdata_in[`TXC_HDR_HI:`TXC_HDR_LO];
    assign txc_blkst = wdata_in[`TXC_BLKST];
    assign txc_valid = wdata_in[`TXC_VALID];

    // Signal set in force, read from the control word itself so that
    // a lane write right after a rate write already obeys the new rate
    assign gen3 = (decode_rate(ctrl_ff[`CTRL_RATE_LO +: 2]) == RATE_SEL_GEN3);
    assign hdr_legal = header_ok(txc_hdr);

    // ****************************************
    // Control register
    // ****************************************
    // Bits 1:0 rate, 2 de-emphasis, 3 detect, 4 idle, 5 swing, 10:8 margin;
    // the other bits read back as written and drive nothing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_ff <= `CTRL_RESET_VAL;
        end else if (wr_ctrl) begin
            ctrl_ff <= wdata_in;
        end
    end

    // Decoded rate for status readback, loaded beside the control word
    // so a read straight after a rate write never shows the old rate
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rate_ff <= RATE_SEL_GEN1;
        end else if (wr_ctrl) begin
            rate_ff <= decode_rate(wdata_in[`CTRL_RATE_LO +: 2]);
        end
    end

    // ****************************************
    // Lane static controls
    // ****************************************
    // Each pin is a flop one cycle behind the control word: the pins stay
    // glitch-free at the cost of one cycle of latency after a write

    // De-emphasis as software loads it after training;
    // there is no retraining logic here, software owns the value
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_deemphasis_sel_out <= 1'h0;
        end else begin
            lane_tx_deemphasis_sel_out <= ctrl_ff[`CTRL_DEEMPH];
        end
    end

    // Receiver detect or loopback request,
    // held for as long as software leaves the bit set
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_rx_detect_request_out <= 1'h0;
        end else begin
            lane_rx_detect_request_out <= ctrl_ff[`CTRL_DETECT];
        end
    end

    // Electrical idle; out of reset the lane stays quiet
    // until software clears the idle bit
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_idle_request_out <= 1'h1;
        end else begin
            lane_tx_idle_request_out <= ctrl_ff[`CTRL_IDLE];
        end
    end

    // Voltage margin code;
    // only simulation models act on it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_voltage_margin_out <= 3'h0;
        end else begin
            lane_tx_voltage_margin_out <= ctrl_ff[`CTRL_MARGIN_HI:`CTRL_MARGIN_LO];
        end
    end

    // Full swing when high, half swing when low;
    // software picks it to suit the channel
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_full_swing_out <= 1'h0;
        end else begin
            lane_tx_full_swing_out <= ctrl_ff[`CTRL_SWING];
        end
    end

    // ****************************************
    // Transmit data path
    // ****************************************
    // Software writes the word first, then its control word. A lone word
    // write shows on the pins at once under the old control word, so at
    // Gen3 mark the lane invalid first if the PHY must not see that pair.
    // Every lane output holds until the next write that touches it.

    // Word register; one full 32-bit word per write,
    // byte 0 in the low bits
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_word_out <= 32'h0;
        end else if (wr_tx_word) begin
            lane_tx_word_out <= wdata_in;
        end
    end

    // Byte flags; bit n tags byte n of the word,
    // zeroed by control word writes made at Gen3, where they mean nothing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_ctrl_byte_flags_out <= 4'h0;
        end else if (wr_txc) begin
            if (gen3) begin
                lane_tx_ctrl_byte_flags_out <= 4'h0;
            end else begin
                lane_tx_ctrl_byte_flags_out <= txc_flags;
            end
        end
    end

    // Skip qualifier as a held level, one value per control word at Gen3.
    // Outside Gen3 it stays valid so the PHY never drops a word.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_skip_qualifier_out <= `SKIP_VALID;
        end else if (!gen3) begin
            lane_tx_skip_qualifier_out <= `SKIP_VALID;
        end else if (wr_txc) begin
            lane_tx_skip_qualifier_out <= txc_valid;
        end
    end

    // Header moves only on valid Gen3 words with a legal code; an illegal
    // code keeps the last good header and is reported in status instead
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_block_header_out <= `HDR_DATA_BLOCK;
        end else if (wr_txc && gen3 && txc_valid && hdr_legal) begin
            lane_tx_block_header_out <= txc_hdr;
        end
    end

    // Block start held at Gen3 until the next valid control word and zero outside Gen3; a skipped word
    // leaves it alone, so it never changes on a cycle marked invalid
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lane_tx_block_start_out <= 1'h0;
        end else if (!gen3) begin
            lane_tx_block_start_out <= 1'h0;
        end else if (wr_txc && txc_valid) begin
            lane_tx_block_start_out <= txc_blkst;
        end
    end

    // ****************************************
    // Status
    // ****************************************
    // Bit 0 flags a bad header until software writes 1 to clear it;
    // bits 2:1 give the rate that the lane is obeying

    // Bad-header event and its software clear
    assign bad_hdr_evt = wr_txc && gen3 && txc_valid && !hdr_legal;
    assign bad_hdr_clr = wr_status && wdata_in[`STATUS_BAD_HDR];

    // Sticky bad-header flag; a new bad header wins over the clear
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bad_hdr_ff <= 1'h0;
        end else if (bad_hdr_evt) begin
            bad_hdr_ff <= 1'h1;
        end else if (bad_hdr_clr) begin
            bad_hdr_ff <= 1'h0;
        end
    end

    // Count of control words written; wraps,
    // so software takes differences of two reads
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sent_ff <= 32'h0;
        end else if (wr_txc) begin
            sent_ff <= sent_ff + 32'h1;
        end
    end

    // ****************************************
    // Readback images
    // ****************************************
    // Lane control word in the same bit places as the write that set it
    assign txc_readback = {
        24'h0,
        lane_tx_skip_qualifier_out,
        lane_tx_block_start_out,
        lane_tx_block_header_out,
        lane_tx_ctrl_byte_flags_out
    };

    // Status word: decoded rate above the sticky flag
    assign status_readback = {
        29'h0,
        rate_ff,
        bad_hdr_ff
    };

    // ****************************************
    // Register read
    // ****************************************
    // Read data valid only the cycle after the strobe and zero otherwise,
    // so several blocks can share one read bus through a plain OR
    always_ff @(posedge clk_in) begin
        if (srst_in || !rd_in) begin
            rdata_out <= 32'h0;
        end else begin
            unique case (addr_in)
                `ADDR_CTRL: begin
                    rdata_out <= ctrl_ff;
                end
                `ADDR_TX_WORD: begin
                    rdata_out <= lane_tx_word_out;
                end
                `ADDR_TX_CTRL: begin
                    rdata_out <= txc_readback;
                end
                `ADDR_STATUS: begin
                    rdata_out <= status_readback;
                end
                `ADDR_SENT: begin
                    rdata_out <= sent_ff;
                end
                // Unmapped words read as zero; writes to them are ignored
                default: begin
                    rdata_out <= 32'h0;
                end
            endcase
        end
    end

endmodule : pipe_tx_lane

// ==== rtl/pipe_tx_lane_params.svh ====
`ifndef PIPE_TX_LANE_PARAMS_SVH
`define PIPE_TX_LANE_PARAMS_SVH

// ****************************************
// Register map (word-addressed, plain port)
// ****************************************
`define ADDR_CTRL 4'h0
`define ADDR_TX_WORD 4'h1
`define ADDR_TX_CTRL 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_SENT 4'h4

// ****************************************
// Control register fields
// ****************************************
`define CTRL_RATE_LO 0
`define CTRL_DEEMPH 2
`define CTRL_DETECT 3
`define CTRL_IDLE 4
`define CTRL_SWING 5
`define CTRL_MARGIN_LO 8
`define CTRL_MARGIN_HI 10
`define CTRL_RESET_VAL 32'h0000_0010

// ****************************************
// Transmit word control fields
// ****************************************
`define TXC_FLAGS_LO 0
`define TXC_FLAGS_HI 3
`define TXC_HDR_LO 4
`define TXC_HDR_HI 5
`define TXC_BLKST 6
`define TXC_VALID 7

// ****************************************
// Status register fields
// ****************************************
`define STATUS_BAD_HDR 0

// ****************************************
// Encodings and reset values
// ****************************************
`define RATE_GEN1 2'h0
`define RATE_GEN2 2'h1
`define HDR_ORDERED_SET 2'h1
`define HDR_DATA_BLOCK 2'h2
`define SKIP_INVALID 1'h0
`define SKIP_VALID 1'h1

`endif

// ==== rtl/pipe_tx_lane_pkg.sv ====
package pipe_tx_lane_pkg;
    typedef enum logic [1:0] {
        RATE_SEL_GEN1,
        RATE_SEL_GEN2,
        RATE_SEL_GEN3
    } rate_sel_t;
endpackage : pipe_tx_lane_pkg

// ==== bench/pipe_tx_lane_sva.sv ====
`timescale 1ns/1ps
`include "pipe_tx_lane_params.svh"
module pipe_tx_lane_sva (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [31:0] lane_tx_word_out,
    input wire logic [3:0] lane_tx_ctrl_byte_flags_out,
    input wire logic lane_tx_skip_qualifier_out,
    input wire logic lane_tx_block_start_out,
    input wire logic [1:0] lane_tx_block_header_out,
    input wire logic lane_tx_deemphasis_sel_out,
    input wire logic lane_rx_detect_request_out,
    input wire logic lane_tx_idle_request_out,
    input wire logic [2:0] lane_tx_voltage_margin_out,
    input wire logic lane_tx_full_swing_out
);
    logic [1:0] rate_ff;
    wire ctl_wr = wr_in && addr_in == `ADDR_TX_CTRL;
    // Rate shadow, so lane checks know which signal set applies
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rate_ff <= 2'h0;
        end else if (wr_in && addr_in == `ADDR_CTRL) begin
            rate_ff <= wdata_in[1:0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_word_load: assert property (wr_in && addr_in == `ADDR_TX_WORD
        |=> lane_tx_word_out == $past(wdata_in)) else $error("word not loaded");
    a_flags_load: assert property (ctl_wr && !rate_ff[1]
        |=> lane_tx_ctrl_byte_flags_out == $past(wdata_in[3:0])) else $error("flags wrong");
    a_flags_gen3: assert property (ctl_wr && rate_ff[1]
        |=> lane_tx_ctrl_byte_flags_out == 4'h0) else $error("flags set at gen3");
    a_skip_level: assert property (ctl_wr && rate_ff[1]
        |=> lane_tx_skip_qualifier_out == $past(wdata_in[7])) else $error("skip wrong");
    a_hdr_valid: assert property (ctl_wr && rate_ff[1] && wdata_in[7]
        && (wdata_in[5] ^ wdata_in[4]) |=> lane_tx_block_header_out == $past(wdata_in[5:4])
        && lane_tx_block_start_out == $past(wdata_in[6])) else $error("header not taken");
    a_hdr_hold: assert property (ctl_wr && !wdata_in[7] |=>
        $stable(lane_tx_block_header_out) && $stable(lane_tx_block_start_out))
        else $error("header moved on invalid");
    a_ctrl_copy: assert property ($past(wr_in && !srst_in && addr_in == `ADDR_CTRL, 2)
        && !$past(srst_in) |-> {lane_tx_voltage_margin_out, lane_tx_full_swing_out,
        lane_tx_idle_request_out, lane_rx_detect_request_out, lane_tx_deemphasis_sel_out}
        == {$past(wdata_in[10:8], 2), $past(wdata_in[5:2], 2)}) else $error("ctrl copy wrong");
    a_rate_status: assert property (rd_in && addr_in == `ADDR_STATUS |=>
        rdata_out[2:1] == (rate_ff[1] ? 2'h2 : rate_ff)) else $error("rate decode wrong");
    a_unmapped_zero: assert property (rd_in && addr_in > `ADDR_SENT |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
endmodule : pipe_tx_lane_sva
bind pipe_tx_lane pipe_tx_lane_sva chk_u (.*);

// ==== bench/pipe_phy_lane_model.sv ====
`timescale 1ns/1ps
module pipe_phy_lane_model (
    input wire logic clk_in,
    input wire logic [31:0] word_in,
    input wire logic skip_in,
    input wire logic idle_in,
    input wire logic detect_in,
    output logic [31:0] rx_word_out,
    output logic detect_seen_out
);
    // Skipped cycles and an idle lane carry nothing onto the wire
    always_ff @(posedge clk_in) begin
        if (skip_in && !idle_in) begin
            rx_word_out <= word_in;
        end
        if (detect_in) begin
            detect_seen_out <= 1'b1;
        end
    end
endmodule : pipe_phy_lane_model

// ==== bench/pipe_tx_lane_tb.sv ====
`timescale 1ns/1ps
`include "pipe_tx_lane_params.svh"
module pipe_tx_lane_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out, lane_tx_word_out, rx_word, rd_v;
    logic [3:0] lane_tx_ctrl_byte_flags_out;
    logic [1:0] lane_tx_block_header_out;
    logic [2:0] lane_tx_voltage_margin_out;
    logic lane_tx_skip_qualifier_out, lane_tx_block_start_out, lane_tx_deemphasis_sel_out;
    logic lane_rx_detect_request_out, lane_tx_idle_request_out, lane_tx_full_swing_out, det;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    pipe_tx_lane dut_u (.*);
    pipe_phy_lane_model phy_u (.clk_in(clk_in), .word_in(lane_tx_word_out),
        .skip_in(lane_tx_skip_qualifier_out), .idle_in(lane_tx_idle_request_out),
        .detect_in(lane_rx_detect_request_out), .rx_word_out(rx_word), .detect_seen_out(det));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // ****
    // Bus tasks: one-cycle strobes, sampled once the edge has landed
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rd_v = rdata_out;
    endtask : rd_reg
    function automatic logic [31:0] lane_st();
        return 32'({lane_tx_ctrl_byte_flags_out, lane_tx_block_header_out,
            lane_tx_block_start_out, lane_tx_skip_qualifier_out});
    endfunction : lane_st
    // Gen1 word with mixed flags, then training-side copies
    task automatic t_gen1();
        rd_reg(`ADDR_CTRL);
        chk(rd_v, `CTRL_RESET_VAL);
        chk(lane_st(), 32'({4'h0, 2'h2, 1'b0, 1'b1}));
        wr_reg(`ADDR_TX_WORD, 32'h4433_2211);
        wr_reg(`ADDR_TX_CTRL, 32'h85);
        chk(lane_tx_word_out, 32'h4433_2211);
        chk(32'(lane_tx_ctrl_byte_flags_out), 32'h5);
        wr_reg(`ADDR_CTRL, 32'h52C);
        repeat (2) @(posedge clk_in);
        #1;
        chk(32'({lane_tx_voltage_margin_out, lane_tx_full_swing_out, lane_tx_idle_request_out,
            lane_rx_detect_request_out, lane_tx_deemphasis_sel_out}), 32'h5B);
        chk(rx_word, 32'h4433_2211);
        chk(32'(det), 32'h1);
        $display("gen1 test done");
    endtask : t_gen1
    // Every rate code, ending at Gen3; then blocks, skips and a bad header
    task automatic t_gen3();
        for (int r = 0; r < 4; r++) begin
            wr_reg(`ADDR_CTRL, 32'(r));
            rd_reg(`ADDR_STATUS);
            chk(32'(rd_v[2:1]), (r > 1) ? 32'h2 : 32'(r));
        end
        wr_reg(`ADDR_TX_WORD, 32'hA5A5_0F0F);
        wr_reg(`ADDR_TX_CTRL, 32'hDF);
        chk(lane_st(), 32'({4'h0, 2'h1, 1'b1, 1'b1}));
        wr_reg(`ADDR_TX_CTRL, 32'h20);
        chk(lane_st(), 32'({4'h0, 2'h1, 1'b1, 1'b0}));
        wr_reg(`ADDR_TX_WORD, 32'h1234_5678);
        @(posedge clk_in);
        #1;
        chk(rx_word, 32'hA5A5_0F0F);
        wr_reg(`ADDR_TX_CTRL, 32'hA0);
        wr_reg(`ADDR_TX_CTRL, 32'hB0);
        chk(lane_st(), 32'({4'h0, 2'h2, 1'b0, 1'b1}));
        rd_reg(`ADDR_STATUS);
        chk(32'(rd_v[0]), 32'h1);
        rd_reg(`ADDR_TX_CTRL);
        chk(rd_v, 32'hA0);
        rd_reg(`ADDR_TX_WORD);
        chk(rd_v, 32'h1234_5678);
        rd_reg(`ADDR_SENT);
        chk(rd_v, 32'h5);
        wr_reg(`ADDR_STATUS, 32'h1);
        rd_reg(`ADDR_STATUS);
        chk(32'(rd_v[0]), 32'h0);
        rd_reg(4'hF);
        chk(rd_v, 32'h0);
        $display("gen3 test done");
    endtask : t_gen3
    task automatic finish_test();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // Hang guard, far above the roughly 56 cycles the tests need
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        t_gen1();
        t_gen3();
        finish_test();
    end
endmodule : pipe_tx_lane_tb
